// ### dv/adc_acquisition_conversion_sequencer_tb.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: 100 MHz clock; control writes are one-cycle pulses
// Notes:   RC oscillator stand-in ticks every seven clocks
module adc_acquisition_conversion_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;
    logic ref_clk, rst_n, converterPowerOn, startRequest, abortRequest, rcTick;
    logic offsetCalibrationRequest, resultJustifySelect, doneFlagClear, comparatorHigh;
    logic resultHighWrite, resultLowWrite, specialEventTrigger, busy, sampling;
    logic conversionDoneIrqFlag, calibrating, eventTimerReset;
    logic [2:0] acquisitionTimeSelect, conversionClockSelect;
    logic [2:0] rcCount = 3'h0;
    logic [3:0] channelSelect, compareUnitModeField, sampledChannel;
    logic [7:0] resultWriteData, portPinLevel, analogPinMask;
    logic [7:0] resultHighByte, resultLowByte, portReadData;
    logic [9:0] trialCode, inputLevel;
    int n_fail, n_checks, offs;
    int acqTab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int divTab[8] = '{2, 8, 32, 7, 4, 16, 64, 7};
    adc_acquisition_conversion_sequencer dut (
        .ref_clk, .rst_n, .converterPowerOn, .channelSelect, .startRequest, .abortRequest,
        .offsetCalibrationRequest, .resultJustifySelect, .acquisitionTimeSelect,
        .conversionClockSelect, .rcTick, .doneFlagClear, .resultHighWrite, .resultLowWrite,
        .resultWriteData, .compareUnitModeField, .specialEventTrigger, .portPinLevel,
        .analogPinMask, .comparatorHigh, .busy, .conversionDoneIrqFlag, .resultHighByte,
        .resultLowByte, .sampling, .sampledChannel, .calibrating, .trialCode,
        .eventTimerReset, .portReadData
    );
    sar_array_model #(.OFFSET_LEVEL(10'h005)) model (.*);
    // Clock and RC tick
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        rcCount <= (rcCount == 3'h6) ? 3'h0 : rcCount + 3'h1;
        rcTick <= (rcCount == 3'h0);
    end
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic startPulse();
        @(posedge ref_clk);
        startRequest <= 1'b1;
        @(posedge ref_clk);
        startRequest <= 1'b0;
        #1;
    endtask
    // Idle: wait for sampling; otherwise wait for busy to fall
    task automatic waitFor(input logic idle, output int c);
        c = 0;
        while ((idle ? sampling : ~busy) !== 1'b1 && c < 9000) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        chk({15'h0, c < 9000}, 16'h1, "timeout");
        if (c >= 9000) conclude();
    endtask
    task automatic doReset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        chk({resultHighByte, resultLowByte} | {busy, sampling, 14'h0}, 16'h0, "rst");
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask
    task automatic convert(input logic [2:0] acq, input logic [2:0] sel, input logic rj,
                           input logic [9:0] lvl);
        int c, lo, e;
        @(posedge ref_clk);
        acquisitionTimeSelect <= acq;
        conversionClockSelect <= sel;
        resultJustifySelect <= rj;
        inputLevel <= lvl;
        channelSelect <= {acq[0], sel};
        analogPinMask <= {acq, sel, 2'h1};
        startPulse();
        chk({14'h0, busy, sampling}, {14'h0, 1'b1, acq != 3'h0}, "start");
        chk({12'h0, sampledChannel}, {12'h0, acq[0], sel}, "chan");
        waitFor(1'b0, c);
        lo = (acqTab[acq] + 11) * divTab[sel] + ((acq == 3'h0) ? 5 : 1);
        e = (sel[1:0] == 2'h3) ? 6 : 0;
        chk({15'h0, c <= lo && c >= lo - e}, 16'h1, "length");
        e = (int'(lvl) > offs) ? int'(lvl) - offs : 0;
        chk({resultHighByte, resultLowByte}, rj ? {6'h0, e[9:0]} : {e[9:0], 6'h0}, "res");
        chk({15'h0, conversionDoneIrqFlag}, 16'h1, "done");
        @(posedge ref_clk);
        doneFlagClear <= 1'b1;
        @(posedge ref_clk);
        doneFlagClear <= 1'b0;
        waitFor(1'b1, c);
        chk({15'h0, conversionDoneIrqFlag}, 16'h0, "clear");
        $display("convert acq %0d sel %0d done", acq, sel);
    endtask
    task automatic testAbort();
        int c;
        @(posedge ref_clk);
        resultHighWrite <= 1'b1;
        resultWriteData <= 8'h5a;
        acquisitionTimeSelect <= 3'h0;
        conversionClockSelect <= 3'h0;
        @(posedge ref_clk);
        resultHighWrite <= 1'b0;
        resultLowWrite <= 1'b1;
        resultWriteData <= 8'hc3;
        @(posedge ref_clk);
        resultLowWrite <= 1'b0;
        startPulse();
        repeat (12) @(posedge ref_clk);
        abortRequest <= 1'b1;
        @(posedge ref_clk);
        abortRequest <= 1'b0;
        #1;
        chk({busy, conversionDoneIrqFlag, 14'h0}, 16'h0, "abort");
        chk({resultHighByte, resultLowByte}, 16'h5ac3, "kept");
        waitFor(1'b1, c);
        $display("abort done");
    endtask
    task automatic trig(input logic [3:0] mode, input logic pwr, input logic expBusy);
        int c;
        logic hit;
        hit = (mode == COMPARE_TRIGGER_MODE);
        @(posedge ref_clk);
        compareUnitModeField <= mode;
        converterPowerOn <= pwr;
        @(posedge ref_clk);
        specialEventTrigger <= 1'b1;
        @(posedge ref_clk);
        specialEventTrigger <= 1'b0;
        #1;
        chk({14'h0, eventTimerReset, busy}, {14'h0, hit, expBusy}, "trig");
        waitFor(1'b0, c);
        @(posedge ref_clk);
        converterPowerOn <= 1'b1;
        waitFor(1'b1, c);
        $display("trigger mode %0h power %0b done", mode, pwr);
    endtask
    task automatic testCalib();
        int c;
        logic [15:0] keep;
        keep = {resultHighByte, resultLowByte};
        @(posedge ref_clk);
        doneFlagClear <= 1'b1;
        @(posedge ref_clk);
        doneFlagClear <= 1'b0;
        offsetCalibrationRequest <= 1'b1;
        acquisitionTimeSelect <= 3'h0;
        startPulse();
        chk({15'h0, calibrating}, 16'h1, "cal run");
        waitFor(1'b0, c);
        chk({resultHighByte, resultLowByte}, keep, "cal res");
        chk({15'h0, conversionDoneIrqFlag}, 16'h1, "cal flag");
        @(posedge ref_clk);
        offsetCalibrationRequest <= 1'b0;
        waitFor(1'b1, c);
        offs = 5;
        convert(3'h2, 3'h0, 1'b1, 10'h100);
        convert(3'h0, 3'h0, 1'b0, 10'h003);
        $display("calibration done");
    endtask
    task automatic testPort();
        @(posedge ref_clk);
        portPinLevel <= 8'hff;
        analogPinMask <= 8'h3c;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({8'h0, portReadData}, 16'h00c3, "port");
        $display("port done");
    endtask
    // Main sequence
    initial begin
        int c;
        {rst_n, converterPowerOn, startRequest, abortRequest, offsetCalibrationRequest} = '0;
        {resultJustifySelect, doneFlagClear, resultHighWrite, resultLowWrite} = '0;
        {specialEventTrigger, acquisitionTimeSelect, conversionClockSelect} = '0;
        {channelSelect, compareUnitModeField, resultWriteData, portPinLevel} = '0;
        {analogPinMask, inputLevel, n_fail, n_checks, offs} = '0;
        doReset();
        @(posedge ref_clk);
        converterPowerOn <= 1'b1;
        waitFor(1'b1, c);
        testPort();
        for (int a = 0; a < 8; a++) begin
            convert(a[2:0], 3'h0, a[0], 10'h2a5 - a[9:0]);
        end
        for (int s = 1; s < 8; s++) begin
            convert(3'h1, s[2:0], 1'b1, 10'h31c);
        end
        testAbort();
        trig(COMPARE_TRIGGER_MODE, 1'b1, 1'b1);
        trig(4'h2, 1'b1, 1'b0);
        trig(COMPARE_TRIGGER_MODE, 1'b0, 1'b0);
        testCalib();
        startPulse();
        repeat (6) @(posedge ref_clk);
        doReset();
        waitFor(1'b1, c);
        conclude();
    end
endmodule // adc_acquisition_conversion_sequencer_tb

// ### dv/adc_seq_monitor.sv
// Purpose: Port assertions for the converter sequencer
// Assumes: Clock select 000 wherever periods are timed in clocks
// Notes:   Sees only the sequencer's top-level ports
module adc_seq_monitor
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control inputs
    input wire logic converterPowerOn,
    input wire logic startRequest,
    input wire logic abortRequest,
    input wire logic offsetCalibrationRequest,
    input wire logic [2:0] acquisitionTimeSelect,
    input wire logic [2:0] conversionClockSelect,
    input wire logic [3:0] compareUnitModeField,
    input wire logic specialEventTrigger,
    input wire logic [7:0] portPinLevel,
    input wire logic [7:0] analogPinMask,
    // Outputs watched
    input wire logic busy,
    input wire logic conversionDoneIrqFlag,
    input wire logic [7:0] resultHighByte,
    input wire logic [7:0] resultLowByte,
    input wire logic sampling,
    input wire logic calibrating,
    input wire logic [9:0] trialCode,
    input wire logic eventTimerReset,
    input wire logic [7:0] portReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Start decode and properties
    // --------------------------------------------------------------
    logic tk;
    logic tn;
    // Start taken in idle; tn excludes the calibration pass
    assign tk = startRequest && converterPowerOn && sampling && !busy;
    assign tn = tk && !offsetCalibrationRequest;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_start; tk |=> busy; endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_zero; tn && acquisitionTimeSelect == ACQ_TIME_RESET |=> !sampling; endproperty
    a_zero: assert property (p_zero) else $error("still sampling");
    property p_acq; tn && acquisitionTimeSelect != ACQ_TIME_RESET |=> sampling; endproperty
    a_acq: assert property (p_acq) else $error("acquire stopped");
    property p_delay;
        tn && acquisitionTimeSelect == 3'h0 && conversionClockSelect == 3'h0
            |-> ##5 trialCode == SAR_FIRST_TRIAL;
    endproperty
    a_delay: assert property (p_delay) else $error("convert start");
    property p_done;
        $fell(busy) && $past(converterPowerOn) && !$past(abortRequest) |-> conversionDoneIrqFlag;
    endproperty
    a_done: assert property (p_done) else $error("no done flag");
    property p_abort;
        abortRequest && busy && converterPowerOn
            |=> !busy && $stable(resultHighByte) && $stable(resultLowByte);
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_post;
        $fell(busy) && converterPowerOn && conversionClockSelect == 3'h0
            |-> !sampling [*3] ##[1:4] sampling;
    endproperty
    a_post: assert property (p_post) else $error("post wait");
    property p_timer;
        specialEventTrigger
            |=> eventTimerReset == ($past(compareUnitModeField) == COMPARE_TRIGGER_MODE);
    endproperty
    a_timer: assert property (p_timer) else $error("timer reset");
    property p_trig;
        specialEventTrigger && compareUnitModeField == COMPARE_TRIGGER_MODE
            && converterPowerOn && sampling && !busy |=> busy;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger");
    property p_port;
        $past(rst_n) |-> portReadData == ($past(portPinLevel) & ~$past(analogPinMask));
    endproperty
    a_port: assert property (p_port) else $error("port read");
    property p_off; !converterPowerOn |=> !busy && !sampling && !calibrating; endproperty
    a_off: assert property (p_off) else $error("power off");
    c_done: cover property (conversionDoneIrqFlag && !busy);
    c_abort: cover property (abortRequest && busy);
    c_cal: cover property (calibrating);
endmodule // adc_seq_monitor

bind adc_acquisition_conversion_sequencer adc_seq_monitor mon (.*);

// ### dv/sar_array_model.sv
// Purpose: Behavioural sample-and-hold and comparator array
// Assumes: comparatorHigh is 1 when the held level is at or above the trial
// Notes:   Calibration compares a fixed internal offset, no channel
module sar_array_model #(
    parameter logic [9:0] OFFSET_LEVEL = 10'h005
) (
    // Clock
    input wire logic ref_clk,
    // Converter control
    input wire logic sampling,
    input wire logic calibrating,
    input wire logic [9:0] trialCode,
    // Analog level and answer
    input wire logic [9:0] inputLevel,
    output logic comparatorHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held;
    // Capacitor tracks the pin only while the switch is closed
    always_ff @(posedge ref_clk) begin
        if (sampling) begin
            held <= inputLevel;
        end
    end
    // Dummy conversion sees the offset alone
    assign comparatorHigh = calibrating ? (OFFSET_LEVEL >= trialCode) : (held >= trialCode);
endmodule // sar_array_model

// ### verilog/adc_acquisition_conversion_sequencer.sv
// Purpose: Acquisition and successive-approximation conversion sequencer
// Assumes: All inputs synchronous to ref_clk; software writes arrive as pulses
// Notes:   The analog array answers each trial code on comparatorHigh
module adc_acquisition_conversion_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Main control
    input wire logic converterPowerOn,
    input wire logic [3:0] channelSelect,
    input wire logic startRequest,
    input wire logic abortRequest,
    input wire logic offsetCalibrationRequest,
    // Timing configuration
    input wire logic resultJustifySelect,
    input wire logic [2:0] acquisitionTimeSelect,
    input wire logic [2:0] conversionClockSelect,
    input wire logic rcTick,
    // Done flag clear
    input wire logic doneFlagClear,
    // Result register writes
    input wire logic resultHighWrite,
    input wire logic resultLowWrite,
    input wire logic [7:0] resultWriteData,
    // Compare unit trigger
    input wire logic [3:0] compareUnitModeField,
    input wire logic specialEventTrigger,
    // Port pins
    input wire logic [7:0] portPinLevel,
    input wire logic [7:0] analogPinMask,
    // Analog array
    input wire logic comparatorHigh,
    // Status
    output logic busy,
    output logic conversionDoneIrqFlag,
    output logic [7:0] resultHighByte,
    output logic [7:0] resultLowByte,
    // Analog array control
    output logic sampling,
    output logic [3:0] sampledChannel,
    output logic calibrating,
    output logic [9:0] trialCode,
    // Timer and port
    output logic eventTimerReset,
    output logic [7:0] portReadData
);
    import adc_seq_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    seq_state_type state;
    seq_state_type next_state;
    logic [4:0] periodCount;
    logic [4:0] next_periodCount;
    logic [2:0] instrCount;
    logic [2:0] next_instrCount;
    logic next_busy;
    logic next_sampling;
    logic [3:0] next_sampledChannel;
    logic next_calibrating;
    logic [9:0] next_trialCode;
    logic [9:0] offset;
    logic [9:0] next_offset;
    logic next_conversionDoneIrqFlag;
    logic [7:0] next_resultHighByte;
    logic [7:0] next_resultLowByte;
    logic next_eventTimerReset;
    logic [7:0] next_portReadData;
    logic tadTick;
    logic dividerRun;
    logic triggerMode;
    logic startNow;
    logic finish;
    logic [9:0] finalCode;
    logic [9:0] corrected;
    logic [3:0] bitIndex;

    // ------------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------------
    // Divider only runs while a sequence is under way
    assign dividerRun = (state != SAMPLING) && (state != START_DELAY);

    tad_clock_divider u_tad_clock_divider (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(dividerRun),
        .clockSelect(conversionClockSelect),
        .rcTick(rcTick),
        .tadTick(tadTick)
    );

    // ------------------------------------------------------------------
    // Start sources
    // ------------------------------------------------------------------
    // Software start or compare trigger; power must be on for either
    assign triggerMode = (compareUnitModeField == COMPARE_TRIGGER_MODE);
    assign startNow = converterPowerOn
        && (startRequest || (specialEventTrigger && triggerMode));
    assign bitIndex = 4'd9 - periodCount[3:0];
    assign finish = (state == CONVERT) && tadTick
        && (periodCount == 5'(CONVERT_PERIODS - 1));
    // Last decision folds into the code on the final period
    assign finalCode = comparatorHigh ? trialCode : (trialCode & ~10'h001);
    // Offset cancel, held at zero rather than wrapping
    assign corrected = (finalCode > offset) ? (finalCode - offset) : 10'h000;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Phase, period counting, busy, sampling and trial code
    always_comb begin
        next_state = state;
        next_periodCount = periodCount;
        next_instrCount = instrCount;
        next_busy = busy;
        next_sampling = sampling;
        next_sampledChannel = channelSelect;
        next_calibrating = calibrating;
        next_trialCode = trialCode;
        next_offset = offset;
        case (state)
            SAMPLING: begin
                next_sampling = converterPowerOn && !calibrating;
                next_busy = 1'b0;
                if (startNow) begin
                    next_busy = 1'b1;
                    next_calibrating = offsetCalibrationRequest;
                    next_periodCount = 5'd0;
                    next_instrCount = 3'd0;
                    if (acquisitionTimeSelect == ACQ_TIME_RESET) begin
                        next_sampling = 1'b0;
                        next_state = START_DELAY;
                    end else begin
                        next_sampling = !offsetCalibrationRequest;
                        next_state = ACQUIRE;
                    end
                end
            end
            START_DELAY: begin
                // One instruction cycle before the conversion clock starts
                next_instrCount = instrCount + 3'd1;
                if (instrCount == 3'(INSTR_CYCLE_CLOCKS - 1)) begin
                    next_state = CONVERT;
                    next_trialCode = SAR_FIRST_TRIAL;
                end
            end
            ACQUIRE: begin
                // Busy stays set; sampling holds its start value until the last period
                if (tadTick) begin
                    next_periodCount = periodCount + 5'd1;
                    if (periodCount == acqPeriods(acquisitionTimeSelect) - 5'd1) begin
                        next_state = CONVERT;
                        next_periodCount = 5'd0;
                        next_sampling = 1'b0;
                        next_trialCode = SAR_FIRST_TRIAL;
                    end
                end
            end
            CONVERT: begin
                if (tadTick) begin
                    next_periodCount = periodCount + 5'd1;
                    if (periodCount < 5'(RESULT_BITS)) begin
                        // Drop the trial bit when the input sits below it
                        if (!comparatorHigh) begin
                            next_trialCode[bitIndex] = 1'b0;
                        end
                        if (bitIndex != 4'd0) begin
                            next_trialCode[bitIndex - 4'd1] = 1'b1;
                        end
                    end
                    if (finish) begin
                        next_state = POST_WAIT;
                        next_periodCount = 5'd0;
                        next_busy = 1'b0;
                        if (calibrating) begin
                            next_offset = trialCode;
                        end
                    end
                end
            end
            POST_WAIT: begin
                next_busy = 1'b0;
                if (tadTick) begin
                    next_periodCount = periodCount + 5'd1;
                    if (periodCount == 5'(WAIT_PERIODS - 1)) begin
                        next_state = SAMPLING;
                        next_calibrating = 1'b0;
                        next_sampling = converterPowerOn;
                    end
                end
            end
            default: begin
                next_state = SAMPLING;
            end
        endcase
        // Clearing busy mid-sequence abandons the partial result
        if (abortRequest && (state != SAMPLING) && (state != POST_WAIT)) begin
            next_state = POST_WAIT;
            next_periodCount = 5'd0;
            next_busy = 1'b0;
            next_sampling = 1'b0;
            next_calibrating = 1'b0;
        end
        // Powering off drops the sequence outright
        if (!converterPowerOn) begin
            next_state = SAMPLING;
            next_busy = 1'b0;
            next_sampling = 1'b0;
            next_calibrating = 1'b0;
        end
    end

    // Register sequencer state; reset leaves the module off and idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SAMPLING;
            periodCount <= 5'd0;
            instrCount <= 3'd0;
            busy <= 1'b0;
            sampling <= 1'b0;
            sampledChannel <= 4'h0;
            calibrating <= 1'b0;
            trialCode <= 10'h000;
            offset <= OFFSET_RESET;
        end else begin
            state <= next_state;
            periodCount <= next_periodCount;
            instrCount <= next_instrCount;
            busy <= next_busy;
            sampling <= next_sampling;
            sampledChannel <= next_sampledChannel;
            calibrating <= next_calibrating;
            trialCode <= next_trialCode;
            offset <= next_offset;
        end
    end

    // ------------------------------------------------------------------
    // Result, flag, timer and port
    // ------------------------------------------------------------------
    // Result pair, done flag with set over clear, timer reset, port masking
    always_comb begin
        next_resultHighByte = resultHighByte;
        next_resultLowByte = resultLowByte;
        if (resultHighWrite) begin
            next_resultHighByte = resultWriteData;
        end
        if (resultLowWrite) begin
            next_resultLowByte = resultWriteData;
        end
        if (finish && !calibrating && !abortRequest) begin
            if (resultJustifySelect) begin
                next_resultHighByte = {6'h00, corrected[9:8]};
                next_resultLowByte = corrected[7:0];
            end else begin
                next_resultHighByte = corrected[9:2];
                next_resultLowByte = {corrected[1:0], 6'h00};
            end
        end
        next_conversionDoneIrqFlag = conversionDoneIrqFlag && !doneFlagClear;
        if (finish && !abortRequest && converterPowerOn) begin
            next_conversionDoneIrqFlag = 1'b1;
        end
        next_eventTimerReset = specialEventTrigger && triggerMode;
        next_portReadData = portPinLevel & ~analogPinMask;
    end

    // Register result and side outputs; result pair clears at reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resultHighByte <= RESULT_BYTE_RESET;
            resultLowByte <= RESULT_BYTE_RESET;
            conversionDoneIrqFlag <= 1'b0;
            eventTimerReset <= 1'b0;
            portReadData <= 8'h00;
        end else begin
            resultHighByte <= next_resultHighByte;
            resultLowByte <= next_resultLowByte;
            conversionDoneIrqFlag <= next_conversionDoneIrqFlag;
            eventTimerReset <= next_eventTimerReset;
            portReadData <= next_portReadData;
        end
    end

endmodule // adc_acquisition_conversion_sequencer

// ### verilog/adc_seq_pkg.sv
// Purpose: Shared constants and decode functions for the converter sequencer
// Assumes: ref_clk is the oscillator, 100 MHz
// Notes:   Encodings follow the converter timing configuration fields
package adc_seq_pkg;

    // ------------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------------
    localparam int RESULT_BITS = 10;
    localparam int CONVERT_PERIODS = 11;
    localparam int WAIT_PERIODS = 2;
    localparam logic [2:0] ACQ_TIME_RESET = 3'h0;
    localparam logic [3:0] COMPARE_TRIGGER_MODE = 4'hb;
    localparam logic [1:0] CLOCK_SEL_RC = 2'h3;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [7:0] RESULT_BYTE_RESET = 8'h00;
    localparam logic [9:0] OFFSET_RESET = 10'h000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int INSTR_CYCLE_CLOCKS = (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Sequencer phases
    typedef enum logic [2:0] {
        SAMPLING, START_DELAY, ACQUIRE, CONVERT, POST_WAIT
    } seq_state_type;

    // Oscillator periods per conversion period for a clock-select code
    function automatic logic [6:0] tadDivide(input logic [2:0] sel);
        case (sel)
            3'h0: tadDivide = 7'd2;
            3'h4: tadDivide = 7'd4;
            3'h1: tadDivide = 7'd8;
            3'h5: tadDivide = 7'd16;
            3'h2: tadDivide = 7'd32;
            3'h6: tadDivide = 7'd64;
            default: tadDivide = 7'd2;
        endcase
    endfunction

    // Conversion periods of automatic acquisition for a time-select code
    function automatic logic [4:0] acqPeriods(input logic [2:0] sel);
        case (sel)
            3'h0: acqPeriods = 5'd0;
            3'h1: acqPeriods = 5'd2;
            3'h2: acqPeriods = 5'd4;
            3'h3: acqPeriods = 5'd6;
            3'h4: acqPeriods = 5'd8;
            3'h5: acqPeriods = 5'd12;
            3'h6: acqPeriods = 5'd16;
            default: acqPeriods = 5'd20;
        endcase
    endfunction

endpackage

// ### verilog/tad_clock_divider.sv
// Purpose: One-cycle enable per conversion period
// Assumes: rcTick is a synchronous pulse from the converter RC oscillator
// Notes:   Counter restarts whenever run is low, so the first period is whole except with the RC source
module tad_clock_divider
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [2:0] clockSelect,
    input wire logic rcTick,
    // Period enable
    output logic tadTick
);
    import adc_seq_pkg::*;

    logic [6:0] count;
    logic [6:0] next_count;
    logic next_tadTick;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Divided oscillator or RC source picks the period
    always_comb begin
        next_count = count;
        next_tadTick = 1'b0;
        if (!run) begin
            next_count = 7'd0;
        end else if (clockSelect[1:0] == CLOCK_SEL_RC) begin
            next_tadTick = rcTick;
        end else if (count == tadDivide(clockSelect) - 7'd1) begin
            next_count = 7'd0;
            next_tadTick = 1'b1;
        end else begin
            next_count = count + 7'd1;
        end
    end

    // Register divider state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 7'd0;
            tadTick <= 1'b0;
        end else begin
            count <= next_count;
            tadTick <= next_tadTick;
        end
    end

endmodule // tad_clock_divider
